// ---- hw/network_setup_map.svh ----
/*
 * Register offsets, field positions, reset values and counts of the
 * network setup configuration block.
 * Assumes byte addresses on a 32-bit APB, one register per aligned word.
 */
`ifndef NETWORK_SETUP_MAP_SVH
`define NETWORK_SETUP_MAP_SVH

// register byte offsets
`define NS_OFF_SETUP_ONE    12'h000
`define NS_OFF_LINK_CFG     12'h004
`define NS_OFF_NODE_ID      12'h008
`define NS_OFF_STATUS       12'h00C

// network_setup_one field positions
`define NS_S1_DRIVER_BIT    7
`define NS_S1_THRESH_BIT    6
`define NS_S1_RSVD_BIT      5
`define NS_S1_PROMISC_BIT   4
`define NS_S1_PRESCALE_HI   3
`define NS_S1_PRESCALE_LO   1
`define NS_S1_HALF_ARB_BIT  0

// link_cfg field positions
`define NS_LC_OPEN_LINE_BIT 0
`define NS_LC_MULT_HI       2
`define NS_LC_MULT_LO       1

// status field positions
`define NS_ST_EXCESS_BIT    0
`define NS_ST_COUNT_LO      8

// reset values
`define NS_SETUP_ONE_RESET  8'h00
`define NS_LINK_CFG_RESET   3'h0
`define NS_NODE_ID_RESET    8'h00

// refusal thresholds
`define NS_REFUSAL_FEW      8'h04
`define NS_REFUSAL_MANY     8'h80

// prescaler: divisor is base shifted left by the code
`define NS_RATE_DIV_BASE    8'h08
`define NS_RATE_CODE_MAX    3'h4

// clock multiplier codes
`define NS_MULT_BYPASS      2'h0
`define NS_MULT_DOUBLE      2'h1

// arbitration divisors
`define NS_ARB_DIV_FULL     8'h01
`define NS_ARB_DIV_HALF     8'h02

`endif

// ---- hw/network_setup_pkg.sv ----
/*
 * Types and shared decode for the network setup configuration block.
 * Assumes network_setup_map.svh is on the include path.
 */
`include "network_setup_map.svh"

package network_setup_pkg;

  typedef struct packed {
    logic       driver_push_pull;
    logic       refusal_threshold_select;
    logic       reserved;
    logic       promiscuous_receive;
    logic [2:0] rate_prescale_select;
    logic       half_speed_arbitration;
  } setup_one_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] dest_id;
  } rx_req_t;

  typedef struct packed {
    logic accept;
    logic send_ack;
  } rx_resp_t;

  typedef struct packed {
    logic o;
    logic oe;
  } line_pin_t;

  // codes above the documented range fall back to the slowest rate
  function automatic logic [7:0] rate_divisor(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `NS_RATE_CODE_MAX) ? `NS_RATE_CODE_MAX : code;
    return 8'(`NS_RATE_DIV_BASE << c);
  endfunction

endpackage

// ---- hw/rate_divider.sv ----
/*
 * Programmable tick generator: one-cycle tick every divisor enabled cycles.
 * Assumes divisor is at least 1; a divisor change restarts the count.
 */
`timescale 1ns/1ps

module rate_divider #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // control
  input  wire logic [CNT_W-1:0] divisor,
  // output
  output logic                  tick_r
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] divisor_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r   <= '0;
      divisor_r <= '0;
      tick_r    <= 1'b0;
    end else if (ce) begin
      divisor_r <= divisor;
      if (divisor != divisor_r || count_r >= divisor - CNT_W'(1)) begin
        count_r <= '0;
        tick_r  <= (divisor == divisor_r);
      end else begin
        count_r <= count_r + CNT_W'(1);
        tick_r  <= 1'b0;
      end
    end
  end

endmodule // rate_divider

// ---- hw/network_setup_config.sv ----
/*
 * Network setup configuration block: setup register, link configuration,
 * node identity and status over APB, plus the logic they steer: refusal
 * counting, receive filter, line driver, data-rate and arbitration ticks.
 * Assumes a single 10 MHz pclk and synchronous inputs from the core.
 * Read data and the error flag are captured in the setup cycle and stand
 * until the next setup; writes land at the access edge with no wait state.
 * The excess-refusal flag is write-one-to-clear, and a new excess in the
 * clearing cycle wins. Both ticks run at pclk rate: the doubled clock is
 * only reported, so software still owns the prescaler and arbitration
 * limits that go with a faster core clock.
 */
// Notes on behaviour
// - bit 7 picks push-pull when set, open-drain when clear, clear at reset.
// - with bit 6 set the excess-refusal flag sets after four refusals.
// - with bit 6 clear, its reset state, the flag sets after 128 refusals.
// - bit 4 accepts every valid packet whatever its destination, reset clear.
// - in promiscuous receive only packets addressed to our node are acknowledged.
// - bits 3..1 divide the core clock by 8, 16, 32, 64 or 128 for codes 0 to 4.
// - the prescaler resets to code 000, the fastest rate.
// - the slowest rate is the divide-by-128 setting.
// - bit 0 halves the memory arbitration clock, reset clear.
// - a separate bit selects open-line signaling, where the driver choice applies.
// - multiplier code 01 gives a doubled core clock, code 00 keeps it undivided.
`timescale 1ns/1ps
`include "network_setup_map.svh"

module network_setup_config #(
  parameter int ADDR_W = 12,
  parameter int CNT_W  = 8
) (
  // clock, reset, enable
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // refusal events from the token logic
  input  wire logic                         refusal_seen,
  input  wire logic                         enquiry_answered,
  // receive filter
  input  wire network_setup_pkg::rx_req_t   rx_req,
  output network_setup_pkg::rx_resp_t       rx_resp,
  // line driver
  input  wire logic                         tx_pulse,
  output network_setup_pkg::line_pin_t      first_line_output,
  // clocking controls
  output logic                              rate_tick,
  output logic                              arb_tick,
  output logic [1:0]                        clock_multiplier_select,
  output logic                              core_clock_doubled,
  // flags
  output logic                              excess_refusal_flag
);

  network_setup_pkg::setup_one_t setup_r;
  logic                          open_line_r;
  logic [1:0]                    mult_r;
  logic [7:0]                    node_id_r;
  logic                          excess_r;
  logic [CNT_W-1:0]              refusal_cnt_r;
  logic [31:0]                   prdata_r;
  logic                          pslverr_r;
  logic                          accept_r;
  logic                          send_ack_r;
  logic                          line_o_r;
  logic                          line_oe_r;

  logic             setup_phase;
  logic             wr_en;
  logic [3:0]       reg_sel;
  logic             mapped;
  logic [CNT_W-1:0] threshold;
  logic             excess_clr;
  logic [7:0]       rate_div;
  logic [7:0]       arb_div;
  logic             count_full;

  // dividers: index 0 data rate, index 1 arbitration
  localparam int TICKS = 2;
  logic [7:0]       div_sel [TICKS];
  logic [TICKS-1:0] tick_sel;

  // address decode, one hot over the four words
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [3:0] s;
    s = 4'h0;
    if (a == ADDR_W'(`NS_OFF_SETUP_ONE)) begin
      s[0] = 1'b1;
    end else if (a == ADDR_W'(`NS_OFF_LINK_CFG)) begin
      s[1] = 1'b1;
    end else if (a == ADDR_W'(`NS_OFF_NODE_ID)) begin
      s[2] = 1'b1;
    end else if (a == ADDR_W'(`NS_OFF_STATUS)) begin
      s[3] = 1'b1;
    end
    return s;
  endfunction

  // destination match, shared by the accept and acknowledge paths
  function automatic logic for_this_node(input logic [7:0] dest, input logic [7:0] own);
    return dest == own;
  endfunction

  assign setup_phase = psel && !penable;
  assign reg_sel     = decode(paddr);
  assign mapped      = |reg_sel;
  // no wait state: read data is latched in setup, so access answers at once;
  // ce low stretches the access phase rather than dropping the transfer
  assign pready      = psel && penable && ce;
  // a write lands only on a mapped word, at the access edge
  assign wr_en       = pready && pwrite && mapped;
  assign prdata      = prdata_r;
  assign pslverr     = pslverr_r;

  // error captured during the setup cycle, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (ce && setup_phase) begin
      pslverr_r <= !mapped;
    end
  end

  // read data captured during the setup cycle, upper bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce && setup_phase) begin
      prdata_r <= 32'h0000_0000;
      if (!pwrite) begin
        if (reg_sel[0]) begin
          prdata_r[7:0] <= setup_r;
        end else if (reg_sel[1]) begin
          prdata_r[`NS_LC_OPEN_LINE_BIT]        <= open_line_r;
          prdata_r[`NS_LC_MULT_HI:`NS_LC_MULT_LO] <= mult_r;
        end else if (reg_sel[2]) begin
          prdata_r[7:0] <= node_id_r;
        end else if (reg_sel[3]) begin
          prdata_r[`NS_ST_EXCESS_BIT] <= excess_r;
          prdata_r[`NS_ST_COUNT_LO +: CNT_W] <= refusal_cnt_r;
        end
      end
    end
  end

  // setup register; reserved bit is held at zero whatever is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_r <= `NS_SETUP_ONE_RESET;
    end else if (ce && wr_en && reg_sel[0]) begin
      setup_r.driver_push_pull         <= pwdata[`NS_S1_DRIVER_BIT];
      setup_r.refusal_threshold_select <= pwdata[`NS_S1_THRESH_BIT];
      setup_r.reserved                 <= 1'b0;
      setup_r.promiscuous_receive      <= pwdata[`NS_S1_PROMISC_BIT];
      setup_r.rate_prescale_select     <= pwdata[`NS_S1_PRESCALE_HI:`NS_S1_PRESCALE_LO];
      setup_r.half_speed_arbitration   <= pwdata[`NS_S1_HALF_ARB_BIT];
    end
  end

  // link configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_line_r <= 1'b0;
      mult_r      <= `NS_MULT_BYPASS;
    end else if (ce && wr_en && reg_sel[1]) begin
      open_line_r <= pwdata[`NS_LC_OPEN_LINE_BIT];
      mult_r      <= pwdata[`NS_LC_MULT_HI:`NS_LC_MULT_LO];
    end
  end

  // node identity, compared against every received destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_id_r <= `NS_NODE_ID_RESET;
    end else if (ce && wr_en && reg_sel[2]) begin
      node_id_r <= pwdata[7:0];
    end
  end

  // threshold follows bit 6 live; a lowered one is judged at the next edge
  assign threshold  = setup_r.refusal_threshold_select ?
                      CNT_W'(`NS_REFUSAL_FEW) : CNT_W'(`NS_REFUSAL_MANY);
  assign excess_clr = wr_en && reg_sel[3] && pwdata[`NS_ST_EXCESS_BIT];
  // one compare shared by the saturating count and the flag
  assign count_full = refusal_cnt_r >= threshold;

  // refusal count saturates at the threshold so it cannot wrap past it;
  // an answered enquiry restarts the count even in a refusal cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refusal_cnt_r <= '0;
    end else if (ce) begin
      if (enquiry_answered) begin
        refusal_cnt_r <= '0;
      end else if (refusal_seen && !count_full) begin
        refusal_cnt_r <= refusal_cnt_r + CNT_W'(1);
      end
    end
  end

  // sticky flag: a new excess in the clearing cycle keeps it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excess_r <= 1'b0;
    end else if (ce) begin
      if (count_full) begin
        excess_r <= 1'b1;
      end else if (excess_clr) begin
        excess_r <= 1'b0;
      end
    end
  end

  assign excess_refusal_flag = excess_r;

  // receive filter: accept decided one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_r <= 1'b0;
    end else if (ce) begin
      accept_r <= rx_req.valid &&
                  (setup_r.promiscuous_receive ||
                   for_this_node(rx_req.dest_id, node_id_r));
    end
  end

  // acknowledge ignores promiscuous receive: only our own packets are answered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_ack_r <= 1'b0;
    end else if (ce) begin
      send_ack_r <= rx_req.valid && for_this_node(rx_req.dest_id, node_id_r);
    end
  end

  assign rx_resp = '{accept: accept_r, send_ack: send_ack_r};

  // line level; open-drain only ever pulls the pin low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_o_r <= 1'b0;
    end else if (ce) begin
      if (open_line_r && !setup_r.driver_push_pull) begin
        line_o_r <= 1'b0;
      end else begin
        line_o_r <= tx_pulse;
      end
    end
  end

  // line enable; open-drain releases the pin between pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_oe_r <= 1'b0;
    end else if (ce) begin
      if (open_line_r && !setup_r.driver_push_pull) begin
        line_oe_r <= tx_pulse;
      end else begin
        line_oe_r <= 1'b1;
      end
    end
  end

  assign first_line_output = '{o: line_o_r, oe: line_oe_r};

  // data rate and arbitration ticks; codes above 4 clamp to divide by 128
  assign rate_div = network_setup_pkg::rate_divisor(setup_r.rate_prescale_select);
  assign arb_div  = setup_r.half_speed_arbitration ?
                    `NS_ARB_DIV_HALF : `NS_ARB_DIV_FULL;
  assign div_sel  = '{rate_div, arb_div};

  // each divider restarts only on a change of its own divisor
  for (genvar i = 0; i < TICKS; i++) begin : g_tick
    rate_divider #(
      .CNT_W   (8)
    ) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .divisor (div_sel[i]),
      .tick_r  (tick_sel[i])
    );
  end

  assign rate_tick = tick_sel[0];
  assign arb_tick  = tick_sel[1];
  assign clock_multiplier_select = mult_r;
  assign core_clock_doubled      = (mult_r == `NS_MULT_DOUBLE);

endmodule // network_setup_config

// ---- verification/network_setup_config_props.sv ----
/* Assertion checker for the network setup block, bound to its top module.
   Assumes ce held high and setup, link and node offsets 0x000/0x004/0x008. */
`timescale 1ns/1ps
module network_setup_config_props #(
  parameter int ADDR_W = 12
) (
  // clock and bus
  input logic                             pclk,
  input logic                             presetn,
  input logic                             psel,
  input logic                             penable,
  input logic                             pwrite,
  input logic [ADDR_W-1:0]                paddr,
  input logic [31:0]                      pwdata,
  // core side
  input logic                             refusal_seen,
  input logic                             enquiry_answered,
  input network_setup_pkg::rx_req_t       rx_req,
  input network_setup_pkg::rx_resp_t      rx_resp,
  input logic                             tx_pulse,
  input network_setup_pkg::line_pin_t     first_line_output,
  input logic                             rate_tick,
  input logic                             arb_tick,
  input logic [1:0]                       clock_multiplier_select,
  input logic                             core_clock_doubled,
  input logic                             excess_refusal_flag
);
  logic [7:0] s1_r, nid_r, cnt_r, thr, div;
  logic [8:0] gap_r;
  logic       ol_r, fresh_r, wr;
  assign wr  = psel & penable & pwrite;
  assign thr = s1_r[6] ? 8'h04 : 8'h80;
  assign div = 8'h08 << ((s1_r[3:1] > 3'h4) ? 3'h4 : s1_r[3:1]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= 8'h00;
      nid_r <= 8'h00;
      ol_r  <= 1'b0;
    end else if (wr) begin
      if (paddr == 'h0) s1_r <= pwdata[7:0] & 8'hdf;
      if (paddr == 'h4) ol_r <= pwdata[0];
      if (paddr == 'h8) nid_r <= pwdata[7:0];
    end
  end
  // saturating mirror of the refusal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 8'h00;
    else if (enquiry_answered) cnt_r <= 8'h00;
    else if (refusal_seen && cnt_r < thr) cnt_r <= cnt_r + 8'h01;
  end
  // first tick after a rate write restarts, so it is not measured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r   <= 9'h001;
      fresh_r <= 1'b1;
    end else begin
      gap_r   <= rate_tick ? 9'h001 : gap_r + 9'h001;
      fresh_r <= (wr && paddr == 'h0) || (fresh_r && !rate_tick);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_line;
    $past(presetn) |-> first_line_output == (($past(ol_r) && !$past(s1_r[7])) ?
      {1'b0, $past(tx_pulse)} : {$past(tx_pulse), 1'b1});
  endproperty
  a_line: assert property (p_line) else $error("line drive wrong");
  property p_few;
    s1_r[6] && cnt_r == 8'h04 |=> excess_refusal_flag;
  endproperty
  a_few: assert property (p_few) else $error("flag late at four");
  property p_many;
    !s1_r[6] && cnt_r == 8'h80 |=> excess_refusal_flag;
  endproperty
  a_many: assert property (p_many) else $error("flag late at 128");
  property p_accept;
    rx_req.valid |=> rx_resp.accept ==
      ($past(s1_r[4]) || $past(rx_req.dest_id) == $past(nid_r));
  endproperty
  a_accept: assert property (p_accept) else $error("accept wrong");
  property p_ack;
    rx_req.valid |=> rx_resp.send_ack == ($past(rx_req.dest_id) == $past(nid_r));
  endproperty
  a_ack: assert property (p_ack) else $error("ack wrong");
  property p_rate;
    rate_tick && !fresh_r |-> gap_r == {1'b0, div};
  endproperty
  a_rate: assert property (p_rate) else $error("rate gap wrong");
  property p_mult;
    core_clock_doubled == (clock_multiplier_select == 2'b01);
  endproperty
  a_mult: assert property (p_mult) else $error("doubled flag wrong");
  property p_arb;
    s1_r[0] [*4] |-> arb_tick != $past(arb_tick);
  endproperty
  a_arb: assert property (p_arb) else $error("half arb not alternating");
  property p_full;
    !s1_r[0] [*3] ##0 $past(presetn, 3) |-> arb_tick;
  endproperty
  a_full: assert property (p_full) else $error("full arb tick missing");
endmodule // network_setup_config_props

// ---- verification/network_node_model.sv ----
/* Model of the far-side nodes: refusals, answers, packets, line pulses.
   Assumes the bench calls its tasks from the pclk domain. */
`timescale 1ns/1ps
module network_node_model (
  // clock
  input  logic                       pclk,
  // toward the block
  output logic                       refusal_seen,
  output logic                       enquiry_answered,
  output network_setup_pkg::rx_req_t rx_req,
  output logic                       tx_pulse
);
  initial begin
    refusal_seen = 1'b0;
    enquiry_answered = 1'b0;
    rx_req = '0;
    tx_pulse = 1'b0;
  end
  // changes every cycle so a stale level never passes for a live one
  always @(posedge pclk) tx_pulse <= ~tx_pulse;
  task automatic refuse(input int n, input int gap);
    repeat (n) begin
      @(posedge pclk);
      refusal_seen <= 1'b1;
      @(posedge pclk);
      refusal_seen <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
  endtask
  task automatic answer();
    @(posedge pclk);
    enquiry_answered <= 1'b1;
    @(posedge pclk);
    enquiry_answered <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    @(posedge pclk);
    rx_req <= {1'b1, d};
    @(posedge pclk);
    rx_req <= {1'b0, ~d};
  endtask
endmodule // network_node_model

// ---- verification/network_setup_config_bench.sv ----
/* Self-checking bench for the network setup block with a node model.
   Assumes the hw package, map header and checker are compiled first. */
`timescale 1ns/1ps
module network_setup_config_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, t;
  logic        refusal_seen, enquiry_answered, tx_pulse, rate_tick, arb_tick;
  logic        core_clock_doubled, excess_refusal_flag;
  logic [1:0]  clock_multiplier_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, seed;
  network_setup_pkg::rx_req_t   rx_req;
  network_setup_pkg::rx_resp_t  rx_resp;
  network_setup_pkg::line_pin_t first_line_output;
  int          mismatches, num_checks, n;
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  network_setup_config network_setup_config_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .refusal_seen(refusal_seen),
    .enquiry_answered(enquiry_answered), .rx_req(rx_req), .rx_resp(rx_resp),
    .tx_pulse(tx_pulse), .first_line_output(first_line_output), .rate_tick(rate_tick),
    .arb_tick(arb_tick), .clock_multiplier_select(clock_multiplier_select),
    .core_clock_doubled(core_clock_doubled), .excess_refusal_flag(excess_refusal_flag));
  network_node_model network_node_model_i (.pclk(pclk), .refusal_seen(refusal_seen),
    .enquiry_answered(enquiry_answered), .rx_req(rx_req), .tx_pulse(tx_pulse));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bound(input int k);
    if (k >= 300) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 300);
    bound(k);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick_gap(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rate_tick !== 1'b1 && k < 300);
    bound(k);
  endtask
  task automatic arb_count(input int exp);
    repeat (3) @(posedge pclk);
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      n += int'(arb_tick === 1'b1);
    end
    chk("arb_ticks", n, exp);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    num_checks = 0;
    seed = 32'hae99_98f6;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("setup_reset", rd, 32'h0000_0000);
    chk("line_oe", first_line_output.oe, 1'b1);
    // reserved bit kept clear, prescaler codes 0..4 only
    repeat (6) begin
      seed = lfsr(seed);
      d = {24'h0, seed[7:6], 1'b0, seed[4], 3'(seed[3:1] % 3'h5), seed[0]};
      apb(1'b1, 12'h000, d);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("setup_rw", rd, d);
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0040);
    network_node_model_i.answer();
    network_node_model_i.refuse(3, 0);
    repeat (3) @(posedge pclk);
    chk("flag_three", excess_refusal_flag, 1'b0);
    network_node_model_i.refuse(1, 0);
    repeat (2) @(posedge pclk);
    chk("flag_four", excess_refusal_flag, 1'b1);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk("status_four", rd, 32'h0000_0401);
    apb(1'b1, 12'h000, 32'h0000_0000);
    network_node_model_i.answer();
    apb(1'b1, 12'h00c, 32'h0000_0001);
    network_node_model_i.refuse(127, 1);
    chk("flag_127", excess_refusal_flag, 1'b0);
    network_node_model_i.refuse(1, 0);
    repeat (2) @(posedge pclk);
    chk("flag_128", excess_refusal_flag, 1'b1);
    apb(1'b1, 12'h008, 32'h0000_005a);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, 32'(p << 4));
      for (int m = 0; m < 2; m++) begin
        network_node_model_i.send(m ? 8'h5a : 8'ha5);
        @(negedge pclk);
        chk("accept", rx_resp.accept, 32'(p | m));
        chk("ack", rx_resp.send_ack, 32'(m));
      end
    end
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, 12'h000, 32'(c << 1));
      // a tick already due may land before the restart, so skip two
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      chk("rate_gap", n, 32'h0000_0008 << c);
    end
    apb(1'b1, 12'h004, 32'h0000_0001);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, 32'(p << 7));
      @(posedge pclk);
      t = tx_pulse;
      @(posedge pclk);
      chk("line", first_line_output, p ? {t, 1'b1} : {1'b0, t});
    end
    // doubled clock: prescaler zero and half-speed arbitration
    apb(1'b1, 12'h004, 32'h0000_0002);
    apb(1'b1, 12'h000, 32'h0000_0001);
    chk("doubled", core_clock_doubled, 1'b1);
    chk("mult_sel", clock_multiplier_select, 2'b01);
    arb_count(4);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0000);
    // the link write lands at this edge, so look once the ticks are counted
    arb_count(8);
    chk("undoubled", core_clock_doubled, 1'b0);
    chk("mult_bypass", clock_multiplier_select, 2'b00);
    give_verdict();
  end
endmodule // network_setup_config_bench
bind network_setup_config network_setup_config_props #(.ADDR_W(ADDR_W))
  network_setup_config_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .refusal_seen(refusal_seen), .enquiry_answered(enquiry_answered), .rx_req(rx_req),
  .rx_resp(rx_resp), .tx_pulse(tx_pulse), .first_line_output(first_line_output),
  .rate_tick(rate_tick), .arb_tick(arb_tick),
  .clock_multiplier_select(clock_multiplier_select),
  .core_clock_doubled(core_clock_doubled), .excess_refusal_flag(excess_refusal_flag));
